/* dv/dcc_bus_model.sv */
// system bus model answering posted transfer cycles
// assumes one clock; latency varies between one and two cycles
`timescale 1ns/1ps
module dcc_bus_model (
    input wire logic clk_sys, reset,
    input wire dcc_pkg::dcc_bus_req_s bus_req,
    output logic bus_done,
    output logic [15:0] bus_rdata
);
    logic [1:0] n;
    // read data changes every cycle so a stale capture shows
    always_ff @(posedge clk_sys or posedge reset)
    begin
        n <= reset ? 2'h0 : n + 2'h1;
        bus_rdata <= reset ? 16'hA5C3 : bus_rdata + 16'h1357;
        bus_done <= !reset && bus_req.valid && !bus_done && n[0];
    end
endmodule // dcc_bus_model

/* dv/dcc_chk.sv */
// port checker of the transfer control block
// assumes it is bound to dcc_channel_control
`timescale 1ns/1ps
module dcc_chk (
    // clock, reset and apb
    input wire logic        clk_sys, reset, psel, penable, pwrite,
    input wire logic [31:0] paddr, prdata,
    input wire logic        pready, pslverr,
    // transfer bus
    input wire dcc_pkg::dcc_bus_req_s bus_req,
    input wire logic        bus_done,
    input wire logic [15:0] bus_rdata
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    sequence s_rd_done;
        bus_req.valid && !bus_req.write && !bus_req.single && bus_done;
    endsequence
    sequence s_wr_next;
        bus_req.valid && bus_req.write;
    endsequence
    chk_ready_access: assert property (psel && penable |-> pready)
        else $error("pready low in access");
    chk_req_hold: assert property (bus_req.valid && !bus_done |=>
        $stable(bus_req)) else $error("bus request moved");
    chk_dual_first: assert property ($rose(bus_req.valid) &&
        !bus_req.single |-> !bus_req.write) else $error("write first");
    chk_wdata_pass: assert property (s_rd_done |=> s_wr_next ##0
        bus_req.wdata == $past(bus_rdata)) else $error("bad write data");
    chk_unmapped_err: assert property (psel && !penable &&
        paddr[31:8] != 0 |=> pslverr) else $error("no slave error");
    chk_mapped_ok: assert property (psel && !penable &&
        paddr == 32'h38 |=> !pslverr) else $error("false slave error");
    chk_write_zero: assert property (psel && penable && pwrite |->
        prdata == 0) else $error("read data on write");
    chk_error_zero: assert property (psel && penable && pslverr |->
        prdata == 0) else $error("read data on error");
endmodule // dcc_chk
bind dcc_channel_control dcc_chk i_chk (.clk_sys, .reset, .psel,
    .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .bus_req,
    .bus_done, .bus_rdata);

/* dv/test_dcc_channel_control.sv */
// register and transfer tests of the transfer control block
// assumes the bus model as far side and apb as the register bus
`timescale 1ns/1ps
module test_dcc_channel_control;
    logic clk_sys = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, err;
    logic [31:0] paddr = 0, pwdata = 0, prdata, r;
    logic pready, pslverr, bus_done;
    logic [1:0] pin = 2'h3, ack;
    logic [3:0] irq;
    logic [15:0] bus_rdata;
    dcc_pkg::dcc_bus_req_s bus_req;
    int n_fail = 0, comparisons = 0;
    always #50 clk_sys = ~clk_sys;
    dcc_channel_control i_dut (.clk_sys, .reset, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr,
        .transfer_request_pin(pin), .transfer_ack_pin(ack),
        .periph_req('0), .bus_req, .bus_done, .bus_rdata,
        .nmi_event(1'b0), .addr_error_event(1'b0), .end_irq(irq));
    dcc_bus_model i_bus (.clk_sys, .reset, .bus_req, .bus_done, .bus_rdata);
    task end_sim;
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task chk(input string n, input logic [31:0] s, e);
        comparisons++;
        if (s !== e)
        begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    task apb(input logic w, input logic [31:0] a, d);
        int i;
        i = 0;
        @(posedge clk_sys);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk_sys);
        penable <= 1;
        do @(posedge clk_sys); while (pready !== 1'b1 && ++i < 20);
        r = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        if (i >= 20)
        begin
            n_fail++;
            end_sim;
        end
    endtask
    task rc(input string n, input logic [31:0] a, e);
        apb(0, a, 0);
        chk(n, r, e);
    endtask
    // waits for the end request of a channel, bounded
    task wt(input int c);
        int i;
        for (i = 0; i < 3000 && irq[c] !== 1'b1; i++) @(posedge clk_sys);
        if (i >= 3000)
        begin
            n_fail++;
            end_sim;
        end
    endtask
    initial
    begin
        repeat (12) @(posedge clk_sys);
        reset <= 0;
        rc("ctrl0 reset", 32'h38, 0);
        rc("op reset", 32'h20, 0);
        apb(0, 32'h100, 0);
        chk("unmapped error", err, 1);
        apb(1, 32'hB8, 32'hE0);
        rc("ch2 ack options", 32'hB8, 0);
        apb(1, 32'h38, 32'h40);
        // the control write lands at this edge, so look one cycle on
        @(posedge clk_sys);
        chk("ack polarity", ack[0], 1);
        $display("test registers done");
        apb(1, 32'h00, 32'h100);
        apb(1, 32'h10, 32'h200);
        apb(1, 32'h28, 2);
        apb(1, 32'h38, 32'h9C05);
        // no master enable yet, so nothing may move
        repeat (20) @(posedge clk_sys);
        rc("count held", 32'h28, 2);
        apb(1, 32'h20, 1);
        wt(0);
        rc("src step", 32'h00, 32'h102);
        rc("dst step", 32'h10, 32'h1FE);
        rc("count end", 32'h28, 0);
        rc("end flag", 32'h38, 32'h9C07);
        apb(1, 32'h38, 32'h9C07);
        chk("irq on", irq[0], 1);
        apb(1, 32'h38, 32'h9C04);
        rc("flag kept", 32'h38, 32'h9C06);
        apb(1, 32'h38, 32'h9C04);
        rc("flag cleared", 32'h38, 32'h9C04);
        chk("irq off", irq[0], 0);
        $display("test auto request done");
        apb(1, 32'h40, 32'h300);
        apb(1, 32'h68, 1);
        apb(1, 32'h78, 32'h100D);
        pin <= 2'h1;
        for (int i = 0; i < 50 && bus_req.valid !== 1'b1; i++)
            @(posedge clk_sys);
        chk("ack in read", ack[1], 1);
        wt(1);
        pin <= 2'h3;
        rc("word step", 32'h40, 32'h302);
        rc("ch1 flag", 32'h78, 32'h100F);
        $display("test request pin done");
        end_sim;
    end
endmodule // test_dcc_channel_control

/* logic/dcc_channel_control.sv */
// four-channel transfer control: channel registers, request selection,
// acknowledge pins and a one-cycle-at-a-time transfer sequencer
// assumes a system bus that runs each posted cycle and pulses bus_done
// Functional notes
// - destination step: fixed, up, down by size
// - source step: fixed, up, down by size
// - code 0000: external pin, dual address
// - code 0010: pin, single, memory to device
// - code 0011: pin, single, device to memory
// - codes 0100-0111: serial unit requests, dual
// - codes 1000-1011: timer match requests, dual
// - code 1100: internal auto request, dual
// - code 1101: conversion end request
// - ack timing: read cycle or write cycle
// - ack polarity: high or low active
// - request sense: low level or falling edge
// - bus mode: cycle steal or burst
// - size byte or word, sets step
// - end flag sets on normal completion
// - end flag clears by read one, write zero
// - pin options only on channels 0, 1
// - ack option writes only channels 0, 1
// - master enable gates all channels
// - count holds remaining transfers
`timescale 1ns/1ps
module dcc_channel_control
#(
    parameter int NCH = dcc_pkg::NCH
)
(
    // clock and reset
    input  wire logic                   clk_sys,
    input  wire logic                   reset,
    // apb slave
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [31:0]            paddr,
    input  wire logic [31:0]            pwdata,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    // external request and acknowledge pins
    input  wire logic [1:0]             transfer_request_pin,
    output logic      [1:0]             transfer_ack_pin,
    // on-chip request sources
    input  wire dcc_pkg::dcc_periph_req_s periph_req,
    // system bus cycles
    output dcc_pkg::dcc_bus_req_s       bus_req,
    input  wire logic                   bus_done,
    input  wire logic [15:0]            bus_rdata,
    // halting events
    input  wire logic                   nmi_event,
    input  wire logic                   addr_error_event,
    // end of transfer requests
    output logic      [NCH-1:0]         end_irq
);

    logic [15:0]          ctrl      [NCH];
    logic [31:0]          src_addr  [NCH];
    logic [31:0]          dst_addr  [NCH];
    logic [15:0]          xfer_cnt  [NCH];
    logic [NCH-1:0]       te_flag;
    logic [NCH-1:0]       te_armed;
    logic [NCH-1:0]       te_set;
    logic                 master_transfer_enable;
    logic                 ae;
    logic                 nmif;
    logic                 ae_armed;
    logic                 nmif_armed;
    logic [1:0]           prio_mode;
    logic [1:0]           sync1;
    logic [1:0]           sync2;
    logic [1:0]           sync3;
    logic [1:0]           pin_lvl;
    logic [1:0]           edge_pend;
    logic [NCH-1:0]       req_now;
    logic [NCH-1:0]       run_ok;
    logic [NCH-1:0]       cand;
    logic [NCH-1:0]       take;
    logic [NCH-1:0]       step;
    dcc_pkg::dcc_state_e  state;
    logic [1:0]           cur;
    logic [1:0]           pick;
    logic [15:0]          data_hold;
    logic [31:0]          next_src;
    logic [31:0]          next_dst;
    logic                 setup;
    logic                 access;
    logic                 hit;
    logic [1:0]           a_ch;
    logic [3:0]           a_sub;
    logic [31:0]          next_rdata;
    logic                 last;
    logic                 cur_single;
    logic                 cur_d2m;

    // step an address by the transfer size in the selected direction
    function automatic logic [31:0] stepped(input logic [31:0] a,
                                            input logic [1:0]  mode,
                                            input logic        word);
        logic [31:0] inc;
        inc = word ? 32'h00000002 : 32'h00000001;
        unique case (mode)
            dcc_pkg::STEP_INC: stepped = a + inc;
            dcc_pkg::STEP_DEC: stepped = a - inc;
            default:           stepped = a;
        endcase
    endfunction

    // apb decode: channel in bits 7:6, register index in bits 5:2
    assign setup  = psel & ~penable;
    assign access = psel & penable;
    assign pready = access;
    assign a_ch   = paddr[7:6];
    assign a_sub  = paddr[5:2];

    always_comb
    begin
        hit        = 1'b0;
        next_rdata = 32'h00000000;
        if (paddr[1:0] == 2'h0 && paddr[31:8] == 24'h000000)
        begin
            unique case (a_sub)
                dcc_pkg::SUB_SRC:
                begin
                    hit        = 1'b1;
                    next_rdata = src_addr[a_ch];
                end
                dcc_pkg::SUB_DST:
                begin
                    hit        = 1'b1;
                    next_rdata = dst_addr[a_ch];
                end
                dcc_pkg::SUB_CNT:
                begin
                    hit        = 1'b1;
                    next_rdata = {16'h0000, xfer_cnt[a_ch]};
                end
                dcc_pkg::SUB_CTRL:
                begin
                    hit        = 1'b1;
                    next_rdata = {16'h0000, ctrl[a_ch]};
                    next_rdata[dcc_pkg::B_TE] = te_flag[a_ch];
                end
                dcc_pkg::SUB_OP:
                begin
                    hit = (a_ch == 2'h0);
                    if (a_ch == 2'h0)
                    begin
                        next_rdata[dcc_pkg::B_PR+:2]  = prio_mode;
                        next_rdata[dcc_pkg::B_AE]     = ae;
                        next_rdata[dcc_pkg::B_NMIF]   = nmif;
                        next_rdata[dcc_pkg::B_DME]    = master_transfer_enable;
                    end
                end
                default: hit = 1'b0;
            endcase
        end
    end

    // read data and error are caught in the setup cycle, answered in access
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end
        else if (setup)
        begin
            prdata  <= pwrite ? 32'h00000000 : next_rdata;
            pslverr <= ~hit;
        end
    end

    // channel control, addresses and counts
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            for (int i = 0; i < NCH; i++)
            begin
                ctrl[i]     <= dcc_pkg::CTRL_RESET;
                src_addr[i] <= 32'h00000000;
                dst_addr[i] <= 32'h00000000;
                xfer_cnt[i] <= 16'h0000;
            end
        end
        else
        begin
            for (int i = 0; i < NCH; i++)
            begin
                if (step[i])
                begin
                    src_addr[i] <= next_src;
                    dst_addr[i] <= next_dst;
                    xfer_cnt[i] <= xfer_cnt[i] - 16'h0001;
                end
                if (access && pwrite && hit && a_ch == i[1:0])
                begin
                    unique case (a_sub)
                        dcc_pkg::SUB_SRC: src_addr[i] <= pwdata;
                        dcc_pkg::SUB_DST: dst_addr[i] <= pwdata;
                        dcc_pkg::SUB_CNT: xfer_cnt[i] <= pwdata[15:0];
                        dcc_pkg::SUB_CTRL:
                            if (i < dcc_pkg::NEXT_CH)
                                ctrl[i] <= pwdata[15:0];
                            else
                                ctrl[i] <= pwdata[15:0]
                                           & ~dcc_pkg::ACK_OPT_MASK;
                        default: ;
                    endcase
                end
            end
        end
    end

    // end flags: hardware set wins over the software clear
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            te_flag  <= '0;
            te_armed <= '0;
        end
        else
        begin
            for (int i = 0; i < NCH; i++)
            begin
                if (access && hit && a_ch == i[1:0]
                    && a_sub == dcc_pkg::SUB_CTRL)
                begin
                    if (!pwrite)
                        te_armed[i] <= prdata[dcc_pkg::B_TE];
                    else
                        te_armed[i] <= 1'b0;
                end
                if (te_set[i])
                    te_flag[i] <= 1'b1;
                else if (access && pwrite && hit && a_ch == i[1:0]
                         && a_sub == dcc_pkg::SUB_CTRL && te_armed[i]
                         && !pwdata[dcc_pkg::B_TE])
                    te_flag[i] <= 1'b0;
            end
        end
    end

    // operation control: master enable and halting flags
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            master_transfer_enable        <= 1'b0;
            ae         <= 1'b0;
            nmif       <= 1'b0;
            ae_armed   <= 1'b0;
            nmif_armed <= 1'b0;
            prio_mode  <= dcc_pkg::PR_RESET;
        end
        else
        begin
            if (access && hit && a_sub == dcc_pkg::SUB_OP)
            begin
                ae_armed   <= ~pwrite & prdata[dcc_pkg::B_AE];
                nmif_armed <= ~pwrite & prdata[dcc_pkg::B_NMIF];
                if (pwrite)
                begin
                    master_transfer_enable       <= pwdata[dcc_pkg::B_DME];
                    prio_mode <= pwdata[dcc_pkg::B_PR+:2];
                end
            end
            if (addr_error_event)
                ae <= 1'b1;
            else if (access && pwrite && hit && a_sub == dcc_pkg::SUB_OP
                     && ae_armed && !pwdata[dcc_pkg::B_AE])
                ae <= 1'b0;
            if (nmi_event)
                nmif <= 1'b1;
            else if (access && pwrite && hit && a_sub == dcc_pkg::SUB_OP
                     && nmif_armed && !pwdata[dcc_pkg::B_NMIF])
                nmif <= 1'b0;
        end
    end

    // request pins: three flops, a change counts once stages two and three
    // agree, so a one-cycle glitch never reaches the sequencer
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            sync1     <= 2'h3;
            sync2     <= 2'h3;
            sync3     <= 2'h3;
            pin_lvl   <= 2'h3;
            edge_pend <= 2'h0;
        end
        else
        begin
            sync1 <= transfer_request_pin;
            sync2 <= sync1;
            sync3 <= sync2;
            for (int i = 0; i < dcc_pkg::NEXT_CH; i++)
            begin
                if (sync2[i] == sync3[i])
                    pin_lvl[i] <= sync3[i];
                if (sync2[i] == sync3[i] && pin_lvl[i] && !sync3[i])
                    edge_pend[i] <= 1'b1;
                else if (take[i])
                    edge_pend[i] <= 1'b0;
            end
        end
    end

    // request selection per channel
    always_comb
    begin
        for (int i = 0; i < NCH; i++)
        begin
            unique case (ctrl[i][dcc_pkg::B_RS+:4])
                dcc_pkg::RS_EXT_DUAL,
                dcc_pkg::RS_EXT_M2D,
                dcc_pkg::RS_EXT_D2M:
                    if (i < dcc_pkg::NEXT_CH)
                        req_now[i] = ctrl[i][dcc_pkg::B_DS]
                                     ? edge_pend[i] : ~pin_lvl[i];
                    else
                        req_now[i] = 1'b0;
                dcc_pkg::RS_S0_RX:
                    req_now[i] = periph_req.serial0_rx_full_request;
                dcc_pkg::RS_S0_TX:
                    req_now[i] = periph_req.serial0_tx_empty_request;
                dcc_pkg::RS_S1_RX:
                    req_now[i] = periph_req.serial1_rx_full_request;
                dcc_pkg::RS_S1_TX:
                    req_now[i] = periph_req.serial1_tx_empty_request;
                dcc_pkg::RS_TMR0:
                    req_now[i] = periph_req.timer0_match_request;
                dcc_pkg::RS_TMR1:
                    req_now[i] = periph_req.timer1_match_request;
                dcc_pkg::RS_TMR2:
                    req_now[i] = periph_req.timer2_match_request;
                dcc_pkg::RS_TMR3:
                    req_now[i] = periph_req.timer3_match_request;
                dcc_pkg::RS_AUTO:
                    req_now[i] = 1'b1;
                dcc_pkg::RS_CONV:
                    req_now[i] = periph_req.conversion_end_request;
                default:
                    req_now[i] = 1'b0;
            endcase
            run_ok[i] = ctrl[i][dcc_pkg::B_DE] & master_transfer_enable & ~ae & ~nmif
                        & ~te_flag[i];
            end_irq[i] = te_flag[i] & ctrl[i][dcc_pkg::B_IE];
        end
    end

    // fixed order 0, 3, 2, 1; other priority modes are not served here
    assign cand = run_ok & req_now;
    always_comb
    begin
        if (cand[0])
            pick = 2'h0;
        else if (cand[3])
            pick = 2'h3;
        else if (cand[2])
            pick = 2'h2;
        else
            pick = 2'h1;
    end

    assign cur_single = ctrl[cur][dcc_pkg::B_RS+1]
                        && ctrl[cur][dcc_pkg::B_RS+3:dcc_pkg::B_RS+2] == 2'h0;
    assign cur_d2m    = ctrl[cur][dcc_pkg::B_RS+:4] == dcc_pkg::RS_EXT_D2M;
    assign next_src   = stepped(src_addr[cur], ctrl[cur][dcc_pkg::B_SM+:2],
                                ctrl[cur][dcc_pkg::B_TS]);
    assign next_dst   = stepped(dst_addr[cur], ctrl[cur][dcc_pkg::B_DM+:2],
                                ctrl[cur][dcc_pkg::B_TS]);
    assign last       = xfer_cnt[cur] == 16'h0001;

    always_comb
    begin
        take   = '0;
        step   = '0;
        te_set = '0;
        if (state == dcc_pkg::ST_IDLE && cand != '0)
            take[pick] = 1'b1;
        if (bus_done && (state == dcc_pkg::ST_WRITE
                         || state == dcc_pkg::ST_SINGLE))
        begin
            step[cur]   = 1'b1;
            te_set[cur] = last;
        end
    end

    // transfer sequencer: one bus cycle in flight at a time
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            state     <= dcc_pkg::ST_IDLE;
            cur       <= 2'h0;
            data_hold <= 16'h0000;
            bus_req   <= '0;
        end
        else
        begin
            unique case (state)
                dcc_pkg::ST_IDLE:
                    if (cand != '0)
                    begin
                        cur            <= pick;
                        bus_req.valid  <= 1'b1;
                        bus_req.ch     <= pick;
                        bus_req.word   <= ctrl[pick][dcc_pkg::B_TS];
                        if (ctrl[pick][dcc_pkg::B_RS+1] &&
                            ctrl[pick][dcc_pkg::B_RS+3:dcc_pkg::B_RS+2]
                            == 2'h0)
                        begin
                            state          <= dcc_pkg::ST_SINGLE;
                            bus_req.single <= 1'b1;
                            bus_req.write  <= ctrl[pick][dcc_pkg::B_RS];
                            bus_req.addr   <= ctrl[pick][dcc_pkg::B_RS]
                                              ? dst_addr[pick]
                                              : src_addr[pick];
                        end
                        else
                        begin
                            state          <= dcc_pkg::ST_READ;
                            bus_req.single <= 1'b0;
                            bus_req.write  <= 1'b0;
                            bus_req.addr   <= src_addr[pick];
                        end
                    end
                dcc_pkg::ST_READ:
                    if (bus_done)
                    begin
                        data_hold     <= bus_rdata;
                        state         <= dcc_pkg::ST_WRITE;
                        bus_req.write <= 1'b1;
                        bus_req.addr  <= dst_addr[cur];
                        bus_req.wdata <= bus_rdata;
                    end
                dcc_pkg::ST_WRITE,
                dcc_pkg::ST_SINGLE:
                    if (bus_done)
                    begin
                        // burst keeps the bus until the count runs out or run_ok of the channel drops
                        if (ctrl[cur][dcc_pkg::B_TM] && run_ok[cur]
                            && !last)
                        begin
                            state         <= cur_single
                                             ? dcc_pkg::ST_SINGLE
                                             : dcc_pkg::ST_READ;
                            bus_req.write <= cur_single & cur_d2m;
                            bus_req.addr  <= (cur_single && cur_d2m)
                                             ? next_dst : next_src;
                        end
                        else
                        begin
                            state         <= dcc_pkg::ST_IDLE;
                            bus_req.valid <= 1'b0;
                        end
                    end
            endcase
        end
    end

    // acknowledge pins follow the live cycle of their channel
    always_comb
    begin
        for (int i = 0; i < dcc_pkg::NEXT_CH; i++)
            transfer_ack_pin[i] = ctrl[i][dcc_pkg::B_AL] ^
                (cur == i[1:0] && (state == dcc_pkg::ST_SINGLE
                 || (state == dcc_pkg::ST_WRITE
                     && ctrl[i][dcc_pkg::B_AM])
                 || (state == dcc_pkg::ST_READ
                     && !ctrl[i][dcc_pkg::B_AM])));
    end

endmodule // dcc_channel_control

/* logic/dcc_pkg.sv */
// constants, codes and carriers of the four-channel transfer control block
// assumes one 10 MHz system clock and an APB master reaching the registers
package dcc_pkg;
    localparam int          NCH       = 4;
    localparam int          NEXT_CH   = 2;
    // printed offsets, kept as register indices; byte address is four times
    localparam logic [27:0] IDX_BASE  = 28'h5FFFF40;
    localparam logic [27:0] IDX_SRC   = 28'h5FFFF40;
    localparam logic [27:0] IDX_DST   = 28'h5FFFF44;
    localparam logic [27:0] IDX_OP    = 28'h5FFFF48;
    localparam logic [27:0] IDX_CNT   = 28'h5FFFF4A;
    localparam logic [27:0] IDX_CTRL  = 28'h5FFFF4E;
    localparam logic [27:0] IDX_CHSTP = 28'h0000010;
    localparam logic [3:0]  SUB_SRC   = IDX_SRC[3:0];
    localparam logic [3:0]  SUB_DST   = IDX_DST[3:0];
    localparam logic [3:0]  SUB_OP    = IDX_OP[3:0];
    localparam logic [3:0]  SUB_CNT   = IDX_CNT[3:0];
    localparam logic [3:0]  SUB_CTRL  = IDX_CTRL[3:0];
    // channel control field positions
    localparam int          B_DM      = 14;
    localparam int          B_SM      = 12;
    localparam int          B_RS      = 8;
    localparam int          B_AM      = 7;
    localparam int          B_AL      = 6;
    localparam int          B_DS      = 5;
    localparam int          B_TM      = 4;
    localparam int          B_TS      = 3;
    localparam int          B_IE      = 2;
    localparam int          B_TE      = 1;
    localparam int          B_DE      = 0;
    localparam logic [15:0] ACK_OPT_MASK = 16'h00E0;
    localparam logic [15:0] CTRL_RESET   = 16'h0000;
    // operation control field positions
    localparam int          B_PR      = 8;
    localparam int          B_AE      = 2;
    localparam int          B_NMIF    = 1;
    localparam int          B_DME     = 0;
    localparam logic [1:0]  PR_RESET  = 2'h0;
    // address step codes
    localparam logic [1:0]  STEP_FIXED = 2'h0;
    localparam logic [1:0]  STEP_INC   = 2'h1;
    localparam logic [1:0]  STEP_DEC   = 2'h2;
    // request source codes
    localparam logic [3:0]  RS_EXT_DUAL  = 4'h0;
    localparam logic [3:0]  RS_EXT_M2D   = 4'h2;
    localparam logic [3:0]  RS_EXT_D2M   = 4'h3;
    localparam logic [3:0]  RS_S0_RX     = 4'h4;
    localparam logic [3:0]  RS_S0_TX     = 4'h5;
    localparam logic [3:0]  RS_S1_RX     = 4'h6;
    localparam logic [3:0]  RS_S1_TX     = 4'h7;
    localparam logic [3:0]  RS_TMR0      = 4'h8;
    localparam logic [3:0]  RS_TMR1      = 4'h9;
    localparam logic [3:0]  RS_TMR2      = 4'hA;
    localparam logic [3:0]  RS_TMR3      = 4'hB;
    localparam logic [3:0]  RS_AUTO      = 4'hC;
    localparam logic [3:0]  RS_CONV      = 4'hD;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_READ   = 2'b01,
        ST_WRITE  = 2'b10,
        ST_SINGLE = 2'b11
    } dcc_state_e;

    typedef struct packed {
        logic serial0_rx_full_request;
        logic serial0_tx_empty_request;
        logic serial1_rx_full_request;
        logic serial1_tx_empty_request;
        logic timer0_match_request;
        logic timer1_match_request;
        logic timer2_match_request;
        logic timer3_match_request;
        logic conversion_end_request;
    } dcc_periph_req_s;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic        single;
        logic        word;
        logic [1:0]  ch;
        logic [31:0] addr;
        logic [15:0] wdata;
    } dcc_bus_req_s;
endpackage
